//--- rtl/sid_decoder.v
`timescale 1ns/1ps
`default_nettype none
`include "sid_defs.vh"
// Functional notes
// - 0x12 invert c into b, 0x13 negate c, 0x14-0x16 b plus c shifted 1-3.
// - 0x18-0x1A multi-bit shifts of b by c; 0x17 is instruction error.
// - 0x1B-0x1D single shifts of c into b: c plus c, asr 1, lsr 1.
// - 0x1E raises trap; 0x1F is breakpoint, word 0x7FFF.
// - Single-operand 0/1 jump to b plain/delayed; 2/3 also save link.
// - Value 6 clears b only when zero flag clear; 4 and 5 errors.
// - Value 7 uses b as sub-opcode: 0 nop, 1-3 errors.
// - Zero-operand 4/5 return via link only if equal / not equal.
// - Zero-operand 6 jumps to link; 7 same jump delayed.
// - Opcodes 0x10-0x16 scale 5-bit offset by access size, add to b.
// - Opcodes 0x10-0x13 load long, zero byte, zero half, signed half into c.
// - Opcodes 0x14-0x16 store c as long, byte, half.
// - Opcode 0x17 subs 0-3: asl, lsr, asr of b by immediate, subtract.
// - Subs 4-6 set, clear, mask to bit; 7 only tests bit.
// - SP subs 0/1 load long/byte into b; 4 writes sp plus offset to b.
// - SP subs 2/3 store b as long/byte at sp plus offset.
// - Stack-relative offsets are the field scaled by four.
// - SP sub 5 selector b: 0 add to sp, 1 subtract, others error.
// - SP sub 6 pops long then sp plus 4; u 1 to b, 0x11 to link.
// - SP sub 7 sp minus 4 then store; u 1 stores b, 0x11 link.
module sid_decoder
(
   input  wire                      core_clk,
   input  wire                      reset,
   input  wire                      insn_valid,
   input  wire [15:0]               insn_word,
   output reg                       dec_valid,
   output reg  [`SID_OP_W-1:0]      alu_op,
   output reg  [`SID_SRC_W-1:0]     src_a_sel,
   output reg  [`SID_SRC_W-1:0]     src_b_sel,
   output reg  [`SID_REG_W-1:0]     src_a_reg,
   output reg  [`SID_REG_W-1:0]     src_b_reg,
   output reg  [31:0]               imm_value,
   output reg                       dest_we,
   output reg  [`SID_REG_W-1:0]     dest_reg,
   output reg                       flag_write,
   output reg                       mem_load,
   output reg                       mem_store,
   output reg  [`SID_SZ_W-1:0]      mem_size,
   output reg                       mem_signed,
   output reg  [`SID_REG_W-1:0]     mem_data_reg,
   output reg                       mem_addr_pre,
   output reg                       sp_update,
   output reg                       sp_update_sub,
   output reg                       jump_en,
   output reg  [`SID_JMP_W-1:0]     jump_cond,
   output reg                       jump_to_link,
   output reg                       jump_delayed,
   output reg                       link_write,
   output reg                       insn_error,
   output reg                       trap_raise,
   output reg                       break_halt
);
   wire [4:0]                major = insn_word[`SID_MAJ_HI:`SID_MAJ_LO];
   wire [2:0]                f_b   = insn_word[`SID_B_HI:`SID_B_LO];
   wire [2:0]                f_c   = insn_word[`SID_C_HI:`SID_C_LO];
   wire [4:0]                f_u   = insn_word[`SID_U_HI:`SID_U_LO];
   wire [`SID_REG_W-1:0]     reg_b;
   wire [`SID_REG_W-1:0]     reg_c;

   reg  [`SID_OP_W-1:0]      next_alu_op;
   reg  [`SID_SRC_W-1:0]     next_src_a_sel;
   reg  [`SID_SRC_W-1:0]     next_src_b_sel;
   reg  [`SID_REG_W-1:0]     next_src_a_reg;
   reg  [`SID_REG_W-1:0]     next_src_b_reg;
   reg  [31:0]               next_imm_value;
   reg                       next_dest_we;
   reg  [`SID_REG_W-1:0]     next_dest_reg;
   reg                       next_flag_write;
   reg                       next_mem_load;
   reg                       next_mem_store;
   reg  [`SID_SZ_W-1:0]      next_mem_size;
   reg                       next_mem_signed;
   reg  [`SID_REG_W-1:0]     next_mem_data_reg;
   reg                       next_mem_addr_pre;
   reg                       next_sp_update;
   reg                       next_sp_update_sub;
   reg                       next_jump_en;
   reg  [`SID_JMP_W-1:0]     next_jump_cond;
   reg                       next_jump_to_link;
   reg                       next_jump_delayed;
   reg                       next_link_write;
   reg                       next_insn_error;
   reg                       next_trap_raise;
   reg                       next_break_halt;

   sid_reg_map u_map_b
   (
      .field (f_b),
      .index (reg_b)
   );

   sid_reg_map u_map_c
   (
      .field (f_c),
      .index (reg_c)
   );

   // Fill in the ALU part of a register-register or register-immediate op
   task set_alu;
      input [`SID_OP_W-1:0]  op;
      input [`SID_SRC_W-1:0] sb;
      begin
         next_alu_op    = op;
         next_src_a_sel = `SID_SRC_REGB;
         next_src_b_sel = sb;
         next_dest_we   = 1'b1;
         next_dest_reg  = reg_b;
      end
   endtask

   always @*
   begin
      next_alu_op        = `SID_OP_NONE;
      next_src_a_sel     = `SID_SRC_REGB;
      next_src_b_sel     = `SID_SRC_REGC;
      next_src_a_reg     = reg_b;
      next_src_b_reg     = reg_c;
      next_imm_value     = 32'h0000_0000;
      next_dest_we       = 1'b0;
      next_dest_reg      = reg_b;
      next_flag_write    = 1'b0;
      next_mem_load      = 1'b0;
      next_mem_store     = 1'b0;
      next_mem_size      = `SID_SZ_LONG;
      next_mem_signed    = 1'b0;
      next_mem_data_reg  = reg_c;
      next_mem_addr_pre  = 1'b0;
      next_sp_update     = 1'b0;
      next_sp_update_sub = 1'b0;
      next_jump_en       = 1'b0;
      next_jump_cond     = `SID_JMP_NONE;
      next_jump_to_link  = 1'b0;
      next_jump_delayed  = 1'b0;
      next_link_write    = 1'b0;
      next_insn_error    = 1'b0;
      next_trap_raise    = 1'b0;
      next_break_halt    = 1'b0;
      case (major)
         `SID_MAJ_GEN:
         begin
            case (f_u)
               `SID_G_SOP:
               begin
                  case (f_c)
                     3'h0, 3'h1, 3'h2, 3'h3:
                     begin
                        next_jump_en      = 1'b1;
                        next_jump_cond    = `SID_JMP_ALWAYS;
                        next_jump_delayed = f_c[0];
                        next_link_write   = f_c[1];
                     end
                     3'h6:
                     begin
                        set_alu(`SID_OP_CLRNZ, `SID_SRC_REGB);
                        next_src_b_reg = reg_b;
                     end
                     3'h7:
                     begin
                        case (f_b)
                           3'h0: next_alu_op = `SID_OP_NONE;
                           3'h4, 3'h5, 3'h6, 3'h7:
                           begin
                              next_jump_en      = 1'b1;
                              next_jump_to_link = 1'b1;
                              next_src_a_reg    = `SID_REG_LINK;
                              next_jump_cond    = (f_b == 3'h4) ? `SID_JMP_EQ :
                                                  (f_b == 3'h5) ? `SID_JMP_NE :
                                                  `SID_JMP_ALWAYS;
                              next_jump_delayed = (f_b == 3'h7);
                           end
                           default: next_insn_error = 1'b1;
                        endcase
                     end
                     default: next_insn_error = 1'b1;
                  endcase
               end
               `SID_G_NOT:
               begin
                  set_alu(`SID_OP_NOT, `SID_SRC_REGC);
               end
               `SID_G_NEG:
               begin
                  set_alu(`SID_OP_NEG, `SID_SRC_REGC);
               end
               `SID_G_ADD1, `SID_G_ADD2, `SID_G_ADD3:
               begin
                  // Immediate carries the shift count applied to c
                  set_alu(`SID_OP_ADD, `SID_SRC_REGC);
                  next_imm_value = {30'h0000_0000, f_u[1:0] - 2'h3};
               end
               `SID_G_ERR17:
               begin
                  next_insn_error = 1'b1;
               end
               `SID_G_ASLM:
               begin
                  set_alu(`SID_OP_ASL, `SID_SRC_REGC);
               end
               `SID_G_LSRM:
               begin
                  set_alu(`SID_OP_LSR, `SID_SRC_REGC);
               end
               `SID_G_ASRM:
               begin
                  set_alu(`SID_OP_ASR, `SID_SRC_REGC);
               end
               `SID_G_ASL1:
               begin
                  set_alu(`SID_OP_ADD, `SID_SRC_REGC);
                  next_src_a_sel = `SID_SRC_REGC;
                  next_src_a_reg = reg_c;
               end
               `SID_G_ASR1, `SID_G_LSR1:
               begin
                  set_alu((f_u == `SID_G_ASR1) ? `SID_OP_ASR : `SID_OP_LSR, `SID_SRC_IMM);
                  next_src_a_sel = `SID_SRC_REGC;
                  next_src_a_reg = reg_c;
                  next_imm_value = 32'h0000_0001;
               end
               `SID_G_TRAP:
               begin
                  next_trap_raise = 1'b1;
               end
               `SID_G_BRK:
               begin
                  next_break_halt = (insn_word == `SID_BRK_WORD);
                  next_insn_error = (insn_word != `SID_BRK_WORD);
               end
               default:
               begin
                  next_alu_op = `SID_OP_NONE;
               end
            endcase
         end
         `SID_MAJ_LD_LO, `SID_MAJ_LDB, `SID_MAJ_LDW, `SID_MAJ_LDWX,
         `SID_MAJ_ST, `SID_MAJ_STB, `SID_MAJ_STW:
         begin
            next_alu_op    = `SID_OP_ADD;
            next_src_b_sel = `SID_SRC_IMM;
            case (major)
               `SID_MAJ_LD_LO, `SID_MAJ_ST:
               begin
                  next_mem_size  = `SID_SZ_LONG;
                  next_imm_value = {25'h000_0000, f_u, 2'b00};
               end
               `SID_MAJ_LDB, `SID_MAJ_STB:
               begin
                  next_mem_size  = `SID_SZ_BYTE;
                  next_imm_value = {27'h000_0000, f_u};
               end
               default:
               begin
                  next_mem_size  = `SID_SZ_HALF;
                  next_imm_value = {26'h000_0000, f_u, 1'b0};
               end
            endcase
            next_mem_load   = (major <= `SID_MAJ_LDWX);
            next_mem_store  = (major >= `SID_MAJ_ST);
            next_mem_signed = (major == `SID_MAJ_LDWX);
            next_dest_we    = next_mem_load;
            next_dest_reg   = reg_c;
         end
         `SID_MAJ_BITIMM:
         begin
            next_imm_value = {27'h000_0000, f_u};
            case (f_c)
               3'h0: set_alu(`SID_OP_ASL, `SID_SRC_IMM);
               3'h1: set_alu(`SID_OP_LSR, `SID_SRC_IMM);
               3'h2: set_alu(`SID_OP_ASR, `SID_SRC_IMM);
               3'h3: set_alu(`SID_OP_SUB, `SID_SRC_IMM);
               3'h4: set_alu(`SID_OP_BSET, `SID_SRC_IMM);
               3'h5: set_alu(`SID_OP_BCLR, `SID_SRC_IMM);
               3'h6: set_alu(`SID_OP_BMSK, `SID_SRC_IMM);
               default:
               begin
                  set_alu(`SID_OP_BTST, `SID_SRC_IMM);
                  next_dest_we    = 1'b0;
                  next_flag_write = 1'b1;
               end
            endcase
         end
         `SID_MAJ_SP:
         begin
            next_src_a_sel    = `SID_SRC_SP;
            next_src_a_reg    = `SID_REG_SP;
            next_src_b_sel    = `SID_SRC_IMM;
            next_alu_op       = `SID_OP_ADD;
            next_imm_value    = {25'h000_0000, f_u, 2'b00};
            next_mem_data_reg = reg_b;
            case (f_c)
               3'h0, 3'h1:
               begin
                  next_mem_load = 1'b1;
                  next_mem_size = f_c[0] ? `SID_SZ_BYTE : `SID_SZ_LONG;
                  next_dest_we  = 1'b1;
               end
               3'h2, 3'h3:
               begin
                  next_mem_store = 1'b1;
                  next_mem_size  = f_c[0] ? `SID_SZ_BYTE : `SID_SZ_LONG;
               end
               3'h4:
               begin
                  next_dest_we = 1'b1;
               end
               3'h5:
               begin
                  if (f_b == 3'h0 || f_b == 3'h1)
                  begin
                     next_alu_op   = f_b[0] ? `SID_OP_SUB : `SID_OP_ADD;
                     next_dest_we  = 1'b1;
                     next_dest_reg = `SID_REG_SP;
                  end
                  else
                  begin
                     next_alu_op     = `SID_OP_NONE;
                     next_insn_error = 1'b1;
                  end
               end
               default:
               begin
                  // Pop reads at sp then adds 4; push subtracts 4 first
                  next_imm_value     = `SID_SP_STEP;
                  next_alu_op        = `SID_OP_NONE;
                  next_mem_load      = !f_c[0];
                  next_mem_store     = f_c[0];
                  next_mem_addr_pre  = f_c[0];
                  next_sp_update     = 1'b1;
                  next_sp_update_sub = f_c[0];
                  next_dest_we       = !f_c[0];
                  if (f_u == `SID_U_REG_LINK)
                  begin
                     next_dest_reg     = `SID_REG_LINK;
                     next_mem_data_reg = `SID_REG_LINK;
                  end
                  else if (f_u != `SID_U_REG_B)
                  begin
                     next_mem_load   = 1'b0;
                     next_mem_store  = 1'b0;
                     next_sp_update  = 1'b0;
                     next_sp_update_sub = 1'b0;
                     next_dest_we    = 1'b0;
                     next_insn_error = 1'b1;
                  end
               end
            endcase
         end
         default:
         begin
            next_alu_op = `SID_OP_NONE;
         end
      endcase
   end

   always @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         dec_valid     <= 1'b0;
         alu_op        <= `SID_OP_NONE;
         src_a_sel     <= `SID_SRC_REGB;
         src_b_sel     <= `SID_SRC_REGB;
         src_a_reg     <= 6'h00;
         src_b_reg     <= 6'h00;
         imm_value     <= 32'h0000_0000;
         dest_we       <= 1'b0;
         dest_reg      <= 6'h00;
         flag_write    <= 1'b0;
         mem_load      <= 1'b0;
         mem_store     <= 1'b0;
         mem_size      <= `SID_SZ_LONG;
         mem_signed    <= 1'b0;
         mem_data_reg  <= 6'h00;
         mem_addr_pre  <= 1'b0;
         sp_update     <= 1'b0;
         sp_update_sub <= 1'b0;
         jump_en       <= 1'b0;
         jump_cond     <= `SID_JMP_NONE;
         jump_to_link  <= 1'b0;
         jump_delayed  <= 1'b0;
         link_write    <= 1'b0;
         insn_error    <= 1'b0;
         trap_raise    <= 1'b0;
         break_halt    <= 1'b0;
      end
      else
      begin
         // Side effects are squashed whenever no instruction is presented
         dec_valid     <= insn_valid;
         alu_op        <= next_alu_op;
         src_a_sel     <= next_src_a_sel;
         src_b_sel     <= next_src_b_sel;
         src_a_reg     <= next_src_a_reg;
         src_b_reg     <= next_src_b_reg;
         imm_value     <= next_imm_value;
         dest_we       <= insn_valid & next_dest_we;
         dest_reg      <= next_dest_reg;
         flag_write    <= insn_valid & next_flag_write;
         mem_load      <= insn_valid & next_mem_load;
         mem_store     <= insn_valid & next_mem_store;
         mem_size      <= insn_valid ? next_mem_size : `SID_SZ_LONG;
         mem_signed    <= insn_valid & next_mem_signed;
         mem_data_reg  <= next_mem_data_reg;
         mem_addr_pre  <= next_mem_addr_pre;
         sp_update     <= insn_valid & next_sp_update;
         sp_update_sub <= insn_valid & next_sp_update_sub;
         jump_en       <= insn_valid & next_jump_en;
         jump_cond     <= insn_valid ? next_jump_cond : `SID_JMP_NONE;
         jump_to_link  <= insn_valid & next_jump_to_link;
         jump_delayed  <= insn_valid & next_jump_delayed;
         link_write    <= insn_valid & next_link_write;
         insn_error    <= insn_valid & next_insn_error;
         trap_raise    <= insn_valid & next_trap_raise;
         break_halt    <= insn_valid & next_break_halt;
      end
   end
endmodule // sid_decoder
`default_nettype wire

//--- include/sid_defs.vh
`ifndef SID_DEFS_VH
`define SID_DEFS_VH
// Major opcodes (instr[15:11])
`define SID_MAJ_GEN      5'h0F
`define SID_MAJ_LD_LO    5'h10
`define SID_MAJ_LDB      5'h11
`define SID_MAJ_LDW      5'h12
`define SID_MAJ_LDWX     5'h13
`define SID_MAJ_ST       5'h14
`define SID_MAJ_STB      5'h15
`define SID_MAJ_STW      5'h16
`define SID_MAJ_BITIMM   5'h17
`define SID_MAJ_SP       5'h18
// Field positions
`define SID_MAJ_HI       15
`define SID_MAJ_LO       11
`define SID_B_HI         10
`define SID_B_LO         8
`define SID_C_HI         7
`define SID_C_LO         5
`define SID_U_HI         4
`define SID_U_LO         0
// General register sub-opcodes
`define SID_G_SOP        5'h00
`define SID_G_NOT        5'h12
`define SID_G_NEG        5'h13
`define SID_G_ADD1       5'h14
`define SID_G_ADD2       5'h15
`define SID_G_ADD3       5'h16
`define SID_G_ERR17      5'h17
`define SID_G_ASLM       5'h18
`define SID_G_LSRM       5'h19
`define SID_G_ASRM       5'h1A
`define SID_G_ASL1       5'h1B
`define SID_G_ASR1       5'h1C
`define SID_G_LSR1       5'h1D
`define SID_G_TRAP       5'h1E
`define SID_G_BRK        5'h1F
`define SID_BRK_WORD     16'h7FFF
// Pop/push u-field selectors
`define SID_U_REG_B      5'h01
`define SID_U_REG_LINK   5'h11
`define SID_SP_STEP      32'h0000_0004
// Operation codes for the execute stage
`define SID_OP_W         5
`define SID_OP_NONE      5'h00
`define SID_OP_ADD       5'h01
`define SID_OP_SUB       5'h02
`define SID_OP_NOT       5'h03
`define SID_OP_NEG       5'h04
`define SID_OP_ASL       5'h05
`define SID_OP_LSR       5'h06
`define SID_OP_ASR       5'h07
`define SID_OP_BSET      5'h08
`define SID_OP_BCLR      5'h09
`define SID_OP_BMSK      5'h0A
`define SID_OP_BTST      5'h0B
`define SID_OP_CLRNZ     5'h0C
`define SID_OP_MOVB      5'h0D
// Operand A/B sources
`define SID_SRC_W        2
`define SID_SRC_REGB     2'h0
`define SID_SRC_REGC     2'h1
`define SID_SRC_SP       2'h2
`define SID_SRC_IMM      2'h3
// Memory access sizes
`define SID_SZ_W         2
`define SID_SZ_LONG      2'h0
`define SID_SZ_BYTE      2'h1
`define SID_SZ_HALF      2'h2
// Register file indices
`define SID_REG_W        6
`define SID_REG_SP       6'h1C
`define SID_REG_LINK     6'h1F
// Jump kinds
`define SID_JMP_W        2
`define SID_JMP_NONE     2'h0
`define SID_JMP_ALWAYS   2'h1
`define SID_JMP_EQ       2'h2
`define SID_JMP_NE       2'h3
`endif

//--- rtl/sid_reg_map.v
`timescale 1ns/1ps
`default_nettype none
`include "sid_defs.vh"
// Maps a 3-bit compact register field onto the full register index
module sid_reg_map
(
   input  wire [2:0]                field,
   output wire [`SID_REG_W-1:0]     index
);
   assign index = field[2] ? {3'b001, 1'b1, field[1:0]} : {3'b000, field};
endmodule // sid_reg_map
`default_nettype wire

//--- tb/sid_decoder_properties.sv
`timescale 1ns/1ps
`default_nettype none
module sid_dec_props
(
   input wire logic        core_clk,
   input wire logic        reset,
   input wire logic        insn_valid,
   input wire logic [15:0] insn_word,
   input wire logic        insn_error,
   input wire logic        trap_raise,
   input wire logic        break_halt,
   input wire logic        mem_load,
   input wire logic        mem_store,
   input wire logic [1:0]  mem_size,
   input wire logic        mem_signed,
   input wire logic [31:0] imm_value,
   input wire logic        sp_update,
   input wire logic        sp_update_sub,
   input wire logic        jump_en,
   input wire logic [1:0]  jump_cond
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   wire logic [4:0] maj = insn_word[15:11];
   wire logic [4:0] u   = insn_word[4:0];
   wire logic       gen = insn_valid && maj == 5'h0F;
   brk_word_a: assert property (insn_valid && insn_word == 16'h7FFF |=> break_halt && !insn_error)
      else $error("breakpoint word not flagged");
   trap_raise_a: assert property (gen && u == 5'h1E |=> trap_raise && !break_halt)
      else $error("trap not raised");
   gen_err_a: assert property (gen && u == 5'h17 |=> insn_error && !trap_raise)
      else $error("reserved sub-opcode not refused");
   ld_scale_a: assert property (insn_valid && maj == 5'h10 |=> mem_load && mem_size == 2'h0 && imm_value == {25'h0, $past(u), 2'h0})
      else $error("long load offset not scaled by four");
   ldx_sign_a: assert property (insn_valid && maj == 5'h13 |=> mem_load && mem_signed && mem_size == 2'h2)
      else $error("signed half load wrong");
   st_byte_a: assert property (insn_valid && maj == 5'h15 |=> mem_store && !mem_load && mem_size == 2'h1 && imm_value == {27'h0, $past(u)})
      else $error("byte store wrong");
   pop_step_a: assert property (insn_valid && maj == 5'h18 && insn_word[7:5] == 3'h6 && u == 5'h11 |=> mem_load && sp_update && !sp_update_sub && imm_value == 32'h4)
      else $error("pop step wrong");
   ret_eq_a: assert property (insn_valid && insn_word == 16'h7CE0 |=> jump_en && jump_cond == 2'h2)
      else $error("return if equal wrong");
endmodule // sid_dec_props
bind sid_decoder sid_dec_props chk_u (.core_clk(core_clk), .reset(reset), .insn_valid(insn_valid),
   .insn_word(insn_word), .insn_error(insn_error), .trap_raise(trap_raise), .break_halt(break_halt),
   .mem_load(mem_load), .mem_store(mem_store), .mem_size(mem_size), .mem_signed(mem_signed),
   .imm_value(imm_value), .sp_update(sp_update), .sp_update_sub(sp_update_sub), .jump_en(jump_en),
   .jump_cond(jump_cond));
`default_nettype wire

//--- tb/sid_fetch_model.sv
`timescale 1ns/1ps
`default_nettype none
// Fetch stage: one word per cycle, a changing word while idle
module sid_fetch_model
(
   input wire logic         core_clk,
   output var logic         insn_valid,
   output var logic [15:0]  insn_word
);
   initial insn_valid = 1'b0;
   initial insn_word = 16'h0000;
   task automatic send(input logic [15:0] w, input logic v);
      @(posedge core_clk);
      insn_valid <= v;
      insn_word <= v ? w : ~insn_word;
   endtask
endmodule // sid_fetch_model
`default_nettype wire

//--- tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "sid_defs.vh"
module tb_top;
   localparam logic [15:0] E = 16'h8000, TR = 16'h4000, BK = 16'h2000, JE = 16'h1000, JD = 16'h0200;
   localparam logic [15:0] JK = 16'h0100, LW = 16'h0080, LD = 16'h0040, ST = 16'h0020, SG = 16'h0004;
   localparam logic [15:0] SU = 16'h0002, SS = 16'h0001;
   localparam logic [39:0] OPS = {`SID_OP_BTST, `SID_OP_BMSK, `SID_OP_BCLR, `SID_OP_BSET,
                                  `SID_OP_SUB, `SID_OP_ASR, `SID_OP_LSR, `SID_OP_ASL};
   logic core_clk = 1'b0, reset = 1'b1;
   wire insn_valid, dec_valid, insn_error, trap_raise, break_halt, jump_en, jump_delayed, jump_to_link;
   wire link_write, mem_load, mem_store, mem_signed, sp_update, sp_update_sub;
   wire [15:0] insn_word;
   wire [4:0]  alu_op;
   wire [31:0] imm_value;
   wire [1:0]  jump_cond, mem_size;
   wire [15:0] got = {insn_error, trap_raise, break_halt, jump_en, jump_cond, jump_delayed, jump_to_link,
                      link_write, mem_load, mem_store, mem_size, mem_signed, sp_update, sp_update_sub};
   int failures = 0, num_checks = 0, cyc = 0, k, m;
   logic [54:0] q[$];
   logic [54:0] e;
   sid_decoder dut_u (.core_clk(core_clk), .reset(reset), .insn_valid(insn_valid), .insn_word(insn_word),
      .dec_valid(dec_valid), .alu_op(alu_op), .src_a_sel(), .src_b_sel(), .src_a_reg(), .src_b_reg(),
      .imm_value(imm_value), .dest_we(), .dest_reg(), .flag_write(), .mem_load(mem_load),
      .mem_store(mem_store), .mem_size(mem_size), .mem_signed(mem_signed), .mem_data_reg(),
      .mem_addr_pre(), .sp_update(sp_update), .sp_update_sub(sp_update_sub), .jump_en(jump_en),
      .jump_cond(jump_cond), .jump_to_link(jump_to_link), .jump_delayed(jump_delayed),
      .link_write(link_write), .insn_error(insn_error), .trap_raise(trap_raise), .break_halt(break_halt));
   sid_fetch_model fm_u (.core_clk(core_clk), .insn_valid(insn_valid), .insn_word(insn_word));
   // Expected {flags, alu_op, alu cared, imm, imm cared}; imm of all ones means not cared
   function automatic logic [54:0] model(input logic [15:0] w);
      logic [4:0] mj, u, a;
      logic [2:0] b, c;
      logic [1:0] z;
      logic [15:0] f;
      logic [31:0] i;
      mj = w[15:11]; b = w[10:8]; c = w[7:5]; u = w[4:0];
      f = 16'h0000; a = `SID_OP_NONE; i = 32'hFFFF_FFFF;
      if (mj == 5'h0F && u == 5'h00)
         case (c)
            3'h4, 3'h5: f = E;
            3'h6: a = `SID_OP_CLRNZ;
            3'h7: f = b == 3'h0 ? 16'h0000 : b < 3'h4 ? E : JE | JK | (b == 3'h4 ? 16'h0800 : b == 3'h5 ? 16'h0C00
                      : 16'h0400) | (b == 3'h7 ? JD : 16'h0000);
            default: f = JE | 16'h0400 | (c[0] ? JD : 16'h0000) | (c[1] ? LW : 16'h0000);
         endcase
      else if (mj == 5'h0F)
         case (u)
            5'h12: a = `SID_OP_NOT;
            5'h13: a = `SID_OP_NEG;
            5'h14, 5'h15, 5'h16: {a, i} = {`SID_OP_ADD, 27'h0, u - 5'h13};
            5'h18: a = `SID_OP_ASL;
            5'h19: a = `SID_OP_LSR;
            5'h1A: a = `SID_OP_ASR;
            5'h1B: a = `SID_OP_ADD;
            5'h1C: {a, i} = {`SID_OP_ASR, 32'h1};
            5'h1D: {a, i} = {`SID_OP_LSR, 32'h1};
            5'h1E: f = TR;
            default: f = (w == 16'h7FFF && u == 5'h1F) ? BK : E;
         endcase
      else if (mj < 5'h17)
      begin
         z = mj[1] ? 2'h2 : mj[1:0];
         i = {27'h0, u} << (z == 2'h0 ? 2 : z == 2'h2 ? 1 : 0);
         f = (mj[2] ? ST : LD) | {11'h0, z, 3'h0} | (mj == 5'h13 ? SG : 16'h0000);
         a = `SID_OP_ADD;
      end
      else if (mj == 5'h17)
         {a, i} = {OPS[c * 5 +: 5], 27'h0, u};
      else
      begin
         case (c)
            3'h0, 3'h1: f = LD | (c[0] ? 16'h0008 : 16'h0000);
            3'h2, 3'h3: f = ST | (c[0] ? 16'h0008 : 16'h0000);
            3'h4: a = `SID_OP_ADD;
            3'h5: {f, a} = b < 3'h2 ? {16'h0, b[0] ? `SID_OP_SUB : `SID_OP_ADD} : {E, `SID_OP_NONE};
            3'h6: f = (u == 5'h01 || u == 5'h11) ? LD | SU : E;
            default: f = (u == 5'h01 || u == 5'h11) ? ST | SU | SS : E;
         endcase
         i = c < 3'h6 ? {25'h0, u, 2'h0} : 32'h4;
         if (f == E)
            i = 32'hFFFF_FFFF;
      end
      return {f, a, a != `SID_OP_NONE, i, i != 32'hFFFF_FFFF};
   endfunction
   task automatic chk(input logic ok, input string what);
      num_checks++;
      if (!ok)
      begin
         failures++;
         $display("CHECK FAILED t=%0t %s", $time, what);
      end
   endtask
   task automatic go(input logic [15:0] w);
      q.push_back(model(w));
      fm_u.send(w, 1'b1);
      if ($urandom % 4 == 0)
         fm_u.send(16'($urandom), 1'b0);
   endtask
   task automatic summarize();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   always @(negedge core_clk)
      if (!reset && dec_valid === 1'b1)
      begin
         e = q.size() > 0 ? q.pop_front() : 55'h0;
         chk(got === e[54:39] && (!e[33] || alu_op === e[38:34]) && (!e[0] || imm_value === e[32:1]), "decode");
      end
      else if (!reset)
         chk(got === 16'h0000, "strobe while idle");
   always @(posedge core_clk)
      if (++cyc == 4000)
      begin
         failures++;
         summarize();
      end
   initial forever #4 core_clk = ~core_clk;
   initial
   begin
      void'($urandom(25570));
      repeat (3) @(posedge core_clk);
      reset <= 1'b0;
      go(16'h7FFF);
      for (k = 0; k < 14; k++) go({5'h0F, 6'($urandom), 5'(5'h12 + k)});
      $display("general group done");
      for (k = 0; k < 16; k++) go(k < 8 ? {5'h0F, 3'($urandom), 3'(k), 5'h00} : {5'h0F, 3'(k), 8'hE0});
      $display("single and zero operand done");
      for (m = 16; m < 24; m++)
         for (k = 0; k < 8; k++) go({5'(m), 3'($urandom), 3'(k), k == 0 ? 5'h00 : k == 1 ? 5'h1F : 5'($urandom)});
      $display("offset and bit immediate done");
      for (k = 0; k < 64; k++) go({5'h18, 3'(k), 3'(k >> 3), k[0] ? 5'h01 : k[1] ? 5'h11 : 5'($urandom)});
      $display("stack group done");
      fm_u.send(16'h0000, 1'b0);
      repeat (4) @(posedge core_clk);
      chk(q.size() == 0, "results missing");
      summarize();
   end
endmodule // tb_top
`default_nettype wire
